/* rtl/cfg_regs_consts.svh */
/*
 * constants of the conversion and option configuration registers:
 * addresses, bit positions, masks, reset values and timing figures.
 * assumes a 100 MHz system clock.
 */
`ifndef CFG_REGS_CONSTS_SVH
`define CFG_REGS_CONSTS_SVH

// register addresses
`define ADDR_CONV_CFG     8'h19
`define ADDR_OPT_CFG      8'h1A
// reset values
`define RST_CONV_CFG      8'h00
`define RST_OPT_CFG       8'h00
// writable bits: reserved and self-clearing bits are never stored
`define WMASK_CONV_CFG    8'h77
`define WMASK_OPT_CFG     8'h7B
// software reset bit of the conversion register
`define BIT_SW_RESET      7
// single-channel select codes
`define SEL_SUPPLY        3'h0
`define SEL_INT_TEMP      3'h1
`define SEL_EXT_OR_IN1    3'h2
`define SEL_IN2           3'h3
`define SEL_IN3           3'h4
`define SEL_IN4           3'h5
// input-pair codes
`define PAIR_INPUTS       2'h0
`define PAIR_EXT_DIODE    2'h2
// converter source codes driven out
`define SRC_SUPPLY        3'h0
`define SRC_INT_TEMP      3'h1
`define SRC_EXT_TEMP      3'h2
`define SRC_IN1           3'h3
`define SRC_IN2           3'h4
`define SRC_IN3           3'h5
`define SRC_IN4           3'h6
// averaging
`define AVG_ON_SAMPLES    5'h10
`define AVG_OFF_SAMPLES   5'h01
// timing figures as printed, and the clock
`define CLK_KHZ           100000
`define BUS_TMO_MS        25
`define ADC_SLOW_KHZ_X10  14
`define ADC_FAST_KHZ_X10  225
`define BUS_TMO_CYC       (`BUS_TMO_MS * `CLK_KHZ)
`define ADC_SLOW_DIV      ((`CLK_KHZ * 10) / `ADC_SLOW_KHZ_X10)
`define ADC_FAST_DIV      ((`CLK_KHZ * 10) / `ADC_FAST_KHZ_X10)

`endif

/* rtl/cfg_regs_pkg.sv */
/*
 * types of the configuration register block.
 * assumes nothing beyond the constants header.
 */
package cfg_regs_pkg;

   // conversion mode register, bit 7 down to bit 0
   typedef struct packed {
      logic       sw_reset;
      logic       bus_tmo_en;
      logic       avg_dis;
      logic       single;
      logic       rsvd3;
      logic [2:0] chan_sel;
   } conv_cfg_t;

   // converter and dac option register, bit 7 down to bit 0
   typedef struct packed {
      logic rsvd7;
      logic dacb_ext_temp;
      logic daca_int_temp;
      logic adc_ref_vdd;
      logic upd_by_reg;
      logic rsvd2;
      logic tvo_10bit;
      logic adc_fast;
   } opt_cfg_t;

   // register access decoded from the serial interface
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

/* rtl/bus_clk_timeout.sv */
/*
 * serial clock low-time watchdog.
 * assumes the clock pin is asynchronous and the limit fits 22 bits.
 */
`timescale 1ns/100ps
`include "cfg_regs_consts.svh"

module bus_clk_timeout #(
   parameter int LIMIT = `BUS_TMO_CYC
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // control
   input  wire logic en_i,
   input  wire logic scl_pin_i,
   // result
   output logic      timeout_o,
   output logic      release_o
);

   logic        scl_m_r;
   logic        scl_s_r;
   logic [21:0] cnt_r;

   // two-flop synchroniser of the clock pin
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
      end else begin
         scl_m_r <= scl_pin_i;
         scl_s_r <= scl_m_r;
      end
   end

   // low-time counter, saturates when it reaches the limit
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || scl_s_r || !en_i) begin
         cnt_r <= '0;
      end else if (cnt_r != 22'(LIMIT)) begin
         cnt_r <= cnt_r + 22'h1;
      end
   end

   // one pulse on timeout, then hold sda free until the clock returns
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || scl_s_r || !en_i) begin
         timeout_o <= 1'b0;
         release_o <= 1'b0;
      end else begin
         timeout_o <= (cnt_r == 22'(LIMIT - 1));
         if (cnt_r == 22'(LIMIT - 1)) begin
            release_o <= 1'b1;
         end
      end
   end

endmodule // bus_clk_timeout

/* rtl/converter_mode_config_regs.sv */
/*
 * conversion mode and dac/adc option registers with the logic they
 * steer: channel choice, cycling, averaging, adc clock, bus timeout,
 * software reset and temperature-proportional dac outputs.
 * assumes the serial interface hands over decoded same-clock accesses
 * and that the first control register lives outside this block.
 */
// What this block does
// - single mode converts supply, temps or inputs by 3-bit code; 110/111 reserved.
// - code 010 converts external diode or first input per input-pair field.
// - cycle bit 0 is round robin, 1 single channel; round robin at reset.
// - measurements average 16 samples unless averaging-disable bit is set.
// - with timeout on, clock low beyond 25 ms abandons transfer, frees data.
// - writing 1 to software reset restores all registers and dac outputs.
// - speed bit picks 1.4 kHz or 22.5 kHz adc clock, fast kills filters.
// - resolution bit picks 8 or 10 bit thermal output; 8-bit variant ignores it.
// - update-source bit picks load pin or register control of dac updates.
// - reference bit picks internal reference or supply for voltage inputs.
// - enable bit drives first dac from internal temperature.
// - enable bit drives second dac from external temperature.
// - the two registers sit at 0x19 and 0x1A.
// - both registers read zero after power-up.
// - update-source bit ignored while shared pin is third voltage input.
// - conversions run only while monitoring enable is set.
// - input pair 00 picks inputs one and two, 10 picks external diode.
`timescale 1ns/100ps
`include "cfg_regs_consts.svh"

module converter_mode_config_regs
   import cfg_regs_pkg::*;
#(
   parameter int   BUS_TMO_LIMIT = `BUS_TMO_CYC,
   parameter int   ADC_SLOW_DIV  = `ADC_SLOW_DIV,
   parameter int   ADC_FAST_DIV  = `ADC_FAST_DIV,
   parameter logic DAC8_ONLY     = 1'b0
) (
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_N_I,
   // register access
   input  wire reg_req_t    REG_REQ_I,
   output logic [7:0]       RDATA_O,
   output logic             RD_HIT_O,
   // first control register fields
   input  wire logic        MON_EN_I,
   input  wire logic [1:0]  INPUT_PAIR_I,
   input  wire logic        SHARED_PIN_IN3_I,
   // conversion engine
   input  wire logic        CONV_DONE_I,
   input  wire logic [9:0]  INT_TEMP_I,
   input  wire logic [9:0]  EXT_TEMP_I,
   output logic             CONV_EN_O,
   output logic [2:0]       ADC_SRC_O,
   output logic [4:0]       AVG_SAMPLES_O,
   output logic             ADC_CLK_EN_O,
   output logic             ADC_FILTER_OFF_O,
   output logic             ADC_REF_VDD_O,
   // dac path
   input  wire logic [11:0] DAC_A_CODE_I,
   input  wire logic [11:0] DAC_B_CODE_I,
   output logic [11:0]      DAC_A_O,
   output logic [11:0]      DAC_B_O,
   output logic             TVO_10BIT_O,
   output logic             DAC_UPD_BY_REG_O,
   // serial bus and device reset
   input  wire logic        SCL_I,
   output logic             SDA_RELEASE_O,
   output logic             BUS_TIMEOUT_O,
   output logic             SOFT_RESET_O
);

   conv_cfg_t   cfg2_r;
   opt_cfg_t    cfg3_r;
   logic        soft_rst_r;
   logic        hit2;
   logic        hit3;
   logic [2:0]  rr_r;
   logic [2:0]  code;
   logic [16:0] div_r;
   logic        speed_r;
   logic        tvo10;

   assign hit2  = (REG_REQ_I.addr == `ADDR_CONV_CFG);
   assign hit3  = (REG_REQ_I.addr == `ADDR_OPT_CFG);
   assign tvo10 = cfg3_r.tvo_10bit & ~DAC8_ONLY;

   ////////////////////////////////////////////////////////////////////
   // software reset request, one cycle after the write
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= REG_REQ_I.wr & hit2 &
                       REG_REQ_I.wdata[`BIT_SW_RESET];
      end
   end
   assign SOFT_RESET_O = soft_rst_r;

   // conversion mode register; reset bit itself is never stored
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r) begin
         cfg2_r <= `RST_CONV_CFG;
      end else if (REG_REQ_I.wr && hit2) begin
         cfg2_r <= REG_REQ_I.wdata & `WMASK_CONV_CFG;
      end
   end

   // option register
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r) begin
         cfg3_r <= `RST_OPT_CFG;
      end else if (REG_REQ_I.wr && hit3) begin
         cfg3_r <= REG_REQ_I.wdata & `WMASK_OPT_CFG;
      end
   end

   // read data, unmapped addresses answer zero without hit
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         RDATA_O  <= 8'h00;
         RD_HIT_O <= 1'b0;
      end else begin
         RD_HIT_O <= REG_REQ_I.rd & (hit2 | hit3);
         if (REG_REQ_I.rd && hit2) begin
            RDATA_O <= cfg2_r;
         end else if (REG_REQ_I.rd && hit3) begin
            RDATA_O <= cfg3_r;
         end else if (REG_REQ_I.rd) begin
            RDATA_O <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // round-robin slot, advances on each finished conversion
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r || cfg2_r.single) begin
         rr_r <= `SEL_SUPPLY;
      end else if (CONV_DONE_I && MON_EN_I) begin
         rr_r <= (rr_r == `SEL_IN4) ? `SEL_SUPPLY : rr_r + 3'h1;
      end
   end

   assign code = cfg2_r.single ? cfg2_r.chan_sel : rr_r;

   // source selection and run enable
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r) begin
         ADC_SRC_O <= `SRC_SUPPLY;
         CONV_EN_O <= 1'b0;
      end else begin
         CONV_EN_O <= MON_EN_I & (code <= `SEL_IN4);
         unique case (code)
            `SEL_SUPPLY:      ADC_SRC_O <= `SRC_SUPPLY;
            `SEL_INT_TEMP:    ADC_SRC_O <= `SRC_INT_TEMP;
            `SEL_EXT_OR_IN1: begin
               if (INPUT_PAIR_I == `PAIR_EXT_DIODE) begin
                  ADC_SRC_O <= `SRC_EXT_TEMP;
               end else begin
                  ADC_SRC_O <= `SRC_IN1;
               end
            end
            `SEL_IN2:         ADC_SRC_O <= `SRC_IN2;
            `SEL_IN3:         ADC_SRC_O <= `SRC_IN3;
            `SEL_IN4:         ADC_SRC_O <= `SRC_IN4;
            default:          ADC_SRC_O <= ADC_SRC_O; // reserved codes
         endcase
      end
   end

   // static option outputs
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r) begin
         AVG_SAMPLES_O    <= `AVG_ON_SAMPLES;
         ADC_FILTER_OFF_O <= 1'b0;
         ADC_REF_VDD_O    <= 1'b0;
         TVO_10BIT_O      <= 1'b0;
         DAC_UPD_BY_REG_O <= 1'b0;
      end else begin
         AVG_SAMPLES_O    <= cfg2_r.avg_dis ? `AVG_OFF_SAMPLES
                                            : `AVG_ON_SAMPLES;
         ADC_FILTER_OFF_O <= cfg3_r.adc_fast;
         ADC_REF_VDD_O    <= cfg3_r.adc_ref_vdd;
         TVO_10BIT_O      <= tvo10;
         DAC_UPD_BY_REG_O <= cfg3_r.upd_by_reg & ~SHARED_PIN_IN3_I;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // adc clock enable divider, restarts on a speed change
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r || speed_r != cfg3_r.adc_fast) begin
         div_r        <= '0;
         ADC_CLK_EN_O <= 1'b0;
         speed_r      <= !RESET_N_I ? 1'b0 :
                         (soft_rst_r ? 1'b0 : cfg3_r.adc_fast);
      end else begin
         if (div_r == (speed_r ? 17'(ADC_FAST_DIV - 1)
                               : 17'(ADC_SLOW_DIV - 1))) begin
            div_r        <= '0;
            ADC_CLK_EN_O <= 1'b1;
         end else begin
            div_r        <= div_r + 17'h1;
            ADC_CLK_EN_O <= 1'b0;
         end
      end
   end

   // dac outputs, temperature-proportional when enabled
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I || soft_rst_r) begin
         DAC_A_O <= 12'h000;
         DAC_B_O <= 12'h000;
      end else begin
         if (cfg3_r.daca_int_temp) begin
            DAC_A_O <= tvo10 ? {INT_TEMP_I, 2'h0}
                             : {INT_TEMP_I[9:2], 4'h0};
         end else begin
            DAC_A_O <= DAC_A_CODE_I;
         end
         if (cfg3_r.dacb_ext_temp) begin
            DAC_B_O <= tvo10 ? {EXT_TEMP_I, 2'h0}
                             : {EXT_TEMP_I[9:2], 4'h0};
         end else begin
            DAC_B_O <= DAC_B_CODE_I;
         end
      end
   end

   // serial clock watchdog
   bus_clk_timeout #(
      .LIMIT     (BUS_TMO_LIMIT)
   ) u_tmo (
      .clk_i     (CLK_SYS_I),
      .rst_n_i   (RESET_N_I),
      .en_i      (cfg2_r.bus_tmo_en),
      .scl_pin_i (SCL_I),
      .timeout_o (BUS_TIMEOUT_O),
      .release_o (SDA_RELEASE_O)
   );

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESET_N_I);

   property p_opt_write;
      REG_REQ_I.wr && hit3 && !soft_rst_r
      |=> cfg3_r == ($past(REG_REQ_I.wdata) & `WMASK_OPT_CFG);
   endproperty
   a_opt_write: assert property (p_opt_write)
      else $error("option register write not stored");

   property p_swrst;
      REG_REQ_I.wr && hit2 && REG_REQ_I.wdata[`BIT_SW_RESET] && !soft_rst_r
      |=> SOFT_RESET_O ##1 (cfg2_r == 8'h00 && cfg3_r == 8'h00
                           && DAC_A_O == 12'h000);
   endproperty
   a_swrst: assert property (p_swrst)
      else $error("software reset did not clear state");

   property p_swbit_zero;
      REG_REQ_I.rd && hit2 |=> RD_HIT_O && !RDATA_O[`BIT_SW_RESET];
   endproperty
   a_swbit_zero: assert property (p_swbit_zero)
      else $error("software reset bit read back set");

   property p_ext_sel;
      cfg2_r.single && cfg2_r.chan_sel == `SEL_EXT_OR_IN1
      && INPUT_PAIR_I == `PAIR_EXT_DIODE && !soft_rst_r
      |=> ADC_SRC_O == `SRC_EXT_TEMP;
   endproperty
   a_ext_sel: assert property (p_ext_sel)
      else $error("code 010 did not pick external diode");

   property p_rr_wrap;
      !cfg2_r.single && CONV_DONE_I && MON_EN_I && rr_r == `SEL_IN4
      && !soft_rst_r |=> rr_r == `SEL_SUPPLY;
   endproperty
   a_rr_wrap: assert property (p_rr_wrap)
      else $error("round robin did not wrap");

   property p_avg;
      cfg2_r.avg_dis && !soft_rst_r |=> AVG_SAMPLES_O == `AVG_OFF_SAMPLES;
   endproperty
   a_avg: assert property (p_avg)
      else $error("averaging not disabled");

   property p_no_tmo;
      !cfg2_r.bus_tmo_en |=> !BUS_TIMEOUT_O;
   endproperty
   a_no_tmo: assert property (p_no_tmo)
      else $error("timeout while disabled");

   property p_mask_pin9;
      SHARED_PIN_IN3_I |=> !DAC_UPD_BY_REG_O;
   endproperty
   a_mask_pin9: assert property (p_mask_pin9)
      else $error("update source not masked");

   property p_mon;
      !MON_EN_I |=> !CONV_EN_O;
   endproperty
   a_mon: assert property (p_mon)
      else $error("conversion enabled without monitoring");

   property p_clk_gap;
      ADC_CLK_EN_O && !soft_rst_r && speed_r == cfg3_r.adc_fast
      |=> !ADC_CLK_EN_O [*8];
   endproperty
   a_clk_gap: assert property (p_clk_gap)
      else $error("adc clock enable too frequent");

   property p_daca;
      cfg3_r.daca_int_temp && !tvo10 && !soft_rst_r
      |=> DAC_A_O == {$past(INT_TEMP_I[9:2]), 4'h0};
   endproperty
   a_daca: assert property (p_daca)
      else $error("dac a not temperature driven");

   c_swrst:  cover property (SOFT_RESET_O);
   c_tmo:    cover property (BUS_TIMEOUT_O);
   c_single: cover property (cfg2_r.single && CONV_EN_O);
   c_dacb:   cover property (cfg3_r.dacb_ext_temp && tvo10);

endmodule // converter_mode_config_regs

/* tb/host_model.sv */
/*
 * host side of the block: issues single-byte register accesses and
 * pulls the serial clock low on command.
 * assumes the device takes a request on the rising clock edge.
 */
`timescale 1ns/100ps

module host_model
   import cfg_regs_pkg::*;
(
   // clock
   input  wire logic       clk_i,
   // toward the device
   output reg_req_t        req_o,
   output logic            scl_o,
   // read answer
   input  wire logic [7:0] rdata_i,
   input  wire logic       hit_i
);
   logic scl_low = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // scl has a pull-up, so it reads high unless pulled low
   assign scl_o = scl_low ? 1'b0 : 1'b1;

   initial req_o = '0;

   // one access held for one taking edge, answer sampled after it
   task automatic access(input logic w, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic h);
      @(posedge clk_i);
      req_o <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge clk_i);
      req_o <= '0;
      #1;
      q = rdata_i;
      h = hit_i;
   endtask
endmodule // host_model

/* tb/tb_converter_mode_config_regs.sv */
/*
 * self-checking bench of the configuration register block.
 * assumes the host model issues accesses and drives the serial clock.
 */
`timescale 1ns/100ps

module tb_converter_mode_config_regs
   import cfg_regs_pkg::*;
;
   localparam int TMO  = 50;
   localparam int SLOW = 20;
   localparam int FAST = 10;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   reg_req_t    req;
   logic [7:0]  rdata, q;
   logic        rd_hit, h, mon_en, shared_in3, conv_done, scl;
   logic [1:0]  input_pair;
   logic [9:0]  int_temp, ext_temp;
   logic [11:0] dac_a_code, dac_b_code, dac_a, dac_b;
   logic        conv_en, adc_clk_en, filt_off, ref_vdd, tvo_10, upd_reg;
   logic [2:0]  adc_src;
   logic [4:0]  avg_samples;
   logic        sda_rel, bus_tmo, soft_rst;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cycles = 0;

   ////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   host_model host (.clk_i(clk_sys), .req_o(req), .scl_o(scl),
                    .rdata_i(rdata), .hit_i(rd_hit));

   converter_mode_config_regs #(.BUS_TMO_LIMIT(TMO),
      .ADC_SLOW_DIV(SLOW), .ADC_FAST_DIV(FAST)) dut (
      .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .REG_REQ_I(req),
      .RDATA_O(rdata), .RD_HIT_O(rd_hit), .MON_EN_I(mon_en),
      .INPUT_PAIR_I(input_pair), .SHARED_PIN_IN3_I(shared_in3),
      .CONV_DONE_I(conv_done), .INT_TEMP_I(int_temp),
      .EXT_TEMP_I(ext_temp), .CONV_EN_O(conv_en), .ADC_SRC_O(adc_src),
      .AVG_SAMPLES_O(avg_samples), .ADC_CLK_EN_O(adc_clk_en),
      .ADC_FILTER_OFF_O(filt_off), .ADC_REF_VDD_O(ref_vdd),
      .DAC_A_CODE_I(dac_a_code), .DAC_B_CODE_I(dac_b_code),
      .DAC_A_O(dac_a), .DAC_B_O(dac_b), .TVO_10BIT_O(tvo_10),
      .DAC_UPD_BY_REG_O(upd_reg), .SCL_I(scl), .SDA_RELEASE_O(sda_rel),
      .BUS_TIMEOUT_O(bus_tmo), .SOFT_RESET_O(soft_rst));

   ////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(1'b1, a, d, q, h);
   endtask

   // read one byte and judge data and hit flag
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic eh);
      host.access(1'b0, a, 8'h00, q, h);
      chk({4'h0, q}, {4'h0, e});
      chk({11'h0, h}, {11'h0, eh});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset_values();
      rd(8'h19, 8'h00, 1'b1);
      rd(8'h1A, 8'h00, 1'b1);
      chk({7'h0, avg_samples}, 12'h010);
      chk({11'h0, conv_en}, 12'h000);
   endtask

   // reserved bits dropped, option outputs and dac sources
   task automatic t_regs();
      wr(8'h19, 8'h7F);
      rd(8'h19, 8'h77, 1'b1);
      wr(8'h1A, 8'hFF);
      rd(8'h1A, 8'h7B, 1'b1);
      rd(8'h1B, 8'h00, 1'b0);
      chk({7'h0, avg_samples}, 12'h001);
      chk({8'h0, filt_off, ref_vdd, tvo_10, upd_reg}, 12'h00F);
      chk(dac_a, {int_temp, 2'b00});
      chk(dac_b, {ext_temp, 2'b00});
      @(posedge clk_sys);
      shared_in3 <= 1'b1;
      settle(3);
      chk({11'h0, upd_reg}, 12'h000);
      @(posedge clk_sys);
      shared_in3 <= 1'b0;
      wr(8'h1A, 8'h61);
      settle(2);
      chk({11'h0, tvo_10}, 12'h000);
      chk(dac_a, {int_temp[9:2], 4'h0});
      wr(8'h1A, 8'h00);
      settle(2);
      chk({9'h0, filt_off, ref_vdd, upd_reg}, 12'h000);
      chk(dac_a, dac_a_code);
      chk(dac_b, dac_b_code);
   endtask

   // every select code under both input-pair settings
   task automatic t_channels();
      logic [2:0] e;
      @(posedge clk_sys);
      mon_en <= 1'b1;
      for (int p = 0; p < 3; p += 2) begin
         @(posedge clk_sys);
         input_pair <= p[1:0];
         for (int i = 0; i < 8; i++) begin
            wr(8'h19, 8'h10 | 8'(i));
            settle(3);
            e = (i < 2) ? 3'(i) : (i == 2) ? ((p == 2) ? 3'h2 : 3'h3)
                : 3'(i + 1);
            chk({11'h0, conv_en}, {11'h0, i < 6});
            if (i < 6) chk({9'h0, adc_src}, {9'h0, e});
         end
      end
      chk({7'h0, avg_samples}, 12'h010);
      @(posedge clk_sys);
      mon_en <= 1'b0;
      settle(3);
      chk({11'h0, conv_en}, 12'h000);
   endtask

   task automatic pulse_done();
      @(posedge clk_sys);
      conv_done <= 1'b1;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      settle(3);
   endtask

   // round robin walks supply, temps, inputs two to four
   task automatic t_round_robin();
      logic [2:0] e;
      wr(8'h19, 8'h00);
      @(posedge clk_sys);
      mon_en <= 1'b1;
      pulse_done();
      repeat (7) begin
         e = (adc_src == 3'h6) ? 3'h0 : (adc_src == 3'h2) ? 3'h4
             : adc_src + 3'h1;
         pulse_done();
         chk({9'h0, adc_src}, {9'h0, e});
         chk({11'h0, conv_en}, 12'h001);
      end
   endtask

   // gap between adc clock pulses at each speed
   task automatic t_adc_clk(input logic fast, input int div);
      int n;
      wr(8'h1A, {7'h00, fast});
      n = 0;
      while (adc_clk_en !== 1'b1 && n < 200) begin
         settle(1);
         n++;
      end
      n = 0;
      do begin
         settle(1);
         n++;
      end while (adc_clk_en !== 1'b1 && n < 200);
      chk(n[11:0], div[11:0]);
   endtask

   // stuck-low serial clock, with and without the timeout bit
   task automatic t_timeout(input logic en);
      int n;
      logic seen;
      wr(8'h19, {1'b0, en, 6'h00});
      @(posedge clk_sys);
      host.scl_low <= 1'b1;
      n = 0;
      seen = 1'b0;
      while (!seen && n < TMO + 20) begin
         settle(1);
         n++;
         seen = (bus_tmo === 1'b1);
      end
      chk({11'h0, seen}, {11'h0, en});
      if (en) chk({11'h0, n >= TMO && n <= TMO + 6}, 12'h001);
      chk({11'h0, sda_rel}, {11'h0, en});
      @(posedge clk_sys);
      host.scl_low <= 1'b0;
      settle(5);
      chk({11'h0, sda_rel}, 12'h000);
   endtask

   // software reset clears both registers and the dac a override
   task automatic t_soft_reset();
      int n;
      wr(8'h1A, 8'h60);
      wr(8'h19, 8'h30);
      wr(8'h19, 8'h80);
      n = 0;
      while (soft_rst !== 1'b1 && n < 4) begin
         settle(1);
         n++;
      end
      chk({11'h0, soft_rst}, 12'h001);
      settle(2);
      rd(8'h19, 8'h00, 1'b1);
      rd(8'h1A, 8'h00, 1'b1);
      chk(dac_a, dac_a_code);
      chk({7'h0, avg_samples}, 12'h010);
   endtask

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      mon_en     = 1'b0;
      input_pair = 2'h2;
      shared_in3 = 1'b0;
      conv_done  = 1'b0;
      int_temp   = 10'h2B7;
      ext_temp   = 10'h1C9;
      dac_a_code = 12'hA5C;
      dac_b_code = 12'h3E1;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset_values();
      t_regs();
      t_channels();
      t_round_robin();
      t_adc_clk(1'b0, SLOW);
      t_adc_clk(1'b1, FAST);
      t_timeout(1'b1);
      t_timeout(1'b0);
      t_soft_reset();
      print_verdict();
   end
endmodule // tb_converter_mode_config_regs
